// >>> css_map.svh
// Offsets, field positions, reset values and timing figures of the start-up sequencer.
`ifndef CSS_MAP_SVH
`define CSS_MAP_SVH
// Register byte offsets on the AXI4-Lite slave.
`define CSS_CTRL_OFS      8'h00
`define CSS_STATUS_OFS    8'h04
`define CSS_STRAP_OFS     8'h08
`define CSS_REF_OFS       8'h0C
// Control register field positions and reset value.
`define CSS_CTRL_FC_BIT   0
`define CSS_CTRL_RESET    32'h0000_0001
// Status register field positions.
`define CSS_STAT_PG_BIT   8
`define CSS_STAT_HS_BIT   9
`define CSS_STAT_LS_BIT   10
`define CSS_STAT_PS_BIT   11
// AXI response codes.
`define CSS_RESP_OKAY     2'h0
`define CSS_RESP_SLVERR   2'h2
// Clock rate in MHz and timing figures in their own units.
`define CSS_CLK_MHZ       32'h0000_007D
`define CSS_INIT_US       32'h0000_012C
`define CSS_POD_US        32'h0000_01F4
`define CSS_SS_BASE_US    32'h0000_03E8
`define CSS_PG_US         32'h0000_03E8
`define CSS_DEGLITCH_NS   32'h0000_00C8
// Full soft-start reference in millivolts.
`define CSS_REF_FULL_MV   32'h0000_0320
`endif

// >>> css_pkg.sv
// Types shared by the start-up sequencer modules.
package css_pkg;
  // Sequencer states, one-hot.
  typedef enum logic [7:0] {
    ST_OFF   = 8'h01,
    ST_INIT  = 8'h02,
    ST_IDLE  = 8'h04,
    ST_DELAY = 8'h08,
    ST_SOFT  = 8'h10,
    ST_WREG  = 8'h20,
    ST_PGDLY = 8'h40,
    ST_RUN   = 8'h80
  } css_state_type;
  // Decoded strap results.
  typedef struct packed {
    logic [1:0] ss_sel;      // Soft-start time: 0=1ms, 1=2ms, 2=4ms, 3=8ms.
    logic       loop_small;  // Loop set for small inductors.
    logic       hiccup;      // Hiccup fault response instead of latch-off.
    logic [1:0] freq_sel;    // 0=600, 1=800, 2=1000, 3=1200 kHz.
    logic       pulse_skip;  // Pulse-skipping mode instead of forced continuous.
  } css_strap_type;
endpackage

// >>> css_strap_if.sv
// Interface carrying strap codes to the decoder and results back.
`timescale 1ns/1ps
interface css_strap_if;
  import css_pkg::*;
  logic [4:0]    ss_code;    // Bit 4 marks an open strap.
  logic [3:0]    mode_code;  // Bit 3 marks an open strap.
  css_strap_type decoded;    // Combined decode result.
  modport decoder (input ss_code, input mode_code, output decoded);
  modport user    (output ss_code, output mode_code, input decoded);
endinterface

// >>> css_strap_decode.sv
// Decoder from strap resistor codes to soft-start, loop, fault and mode settings.
`timescale 1ns/1ps
module css_strap_decode (
  css_strap_if.decoder strap
);
  import css_pkg::*;

  // Codes run in groups of four; an open strap has its own default.
  function automatic css_strap_type decode(input logic [4:0] ss, input logic [3:0] md);
    css_strap_type r;
    r.ss_sel     = ss[4] ? 2'h2 : ss[1:0];
    r.loop_small = ss[4] ? 1'b0 : ss[2];
    r.hiccup     = ss[4] ? 1'b0 : ss[3];
    r.freq_sel   = md[3] ? 2'h1 : md[1:0];
    r.pulse_skip = md[3] ? 1'b0 : md[2];
    return r;
  endfunction

  // Pure decode; the sequencer decides when the result is latched.
  assign strap.decoded = decode(strap.ss_code, strap.mode_code);
endmodule

// >>> css_deglitch.sv
// Two-stage synchroniser and deglitch filter for the turn-on pin.
`timescale 1ns/1ps
module css_deglitch #(
  parameter int CYCLES = 25
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin,
  output logic      level
);
  logic       s1_q;   // First synchroniser stage, read only by the second.
  logic       s2_q;   // Synchronised pin.
  logic [7:0] cnt_q;  // Cycles the synchronised pin has differed from the output.

  // Synchroniser.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
    end
  end

  // A change must persist for the full interval before it is passed on.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= 8'h00;
      level <= 1'b0;
    end
    else if (s2_q == level)
    begin
      cnt_q <= 8'h00;
    end
    else if (cnt_q == 8'(CYCLES - 1))
    begin
      cnt_q <= 8'h00;
      level <= s2_q;
    end
    else
    begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // A short pulse never reaches the output.
  AST_GLITCH_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (level != $past(level)) |-> ($past(s2_q) != $past(level))
      && $past(cnt_q) == 8'(CYCLES - 1))
    else $error("turn-on output changed without a stable input");
endmodule

// >>> css_sequencer.sv
// Start-up and shutdown sequencer with strap latching and an AXI4-Lite register slave.
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "css_map.svh"
module css_sequencer #(
  parameter int ADDR_W     = 8,
  parameter int CNT_W      = 20,
  parameter int INIT_CYC   = `CSS_INIT_US * `CSS_CLK_MHZ,
  parameter int POD_CYC    = `CSS_POD_US * `CSS_CLK_MHZ,
  parameter int PG_CYC     = `CSS_PG_US * `CSS_CLK_MHZ,
  parameter int STEP_CYC   = (`CSS_SS_BASE_US * `CSS_CLK_MHZ) / `CSS_REF_FULL_MV
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              bias_supply_ok,
  input  wire logic              analog_supply_input_ok,
  input  wire logic              turn_on_pin,
  input  wire logic              vout_in_regulation,
  input  wire logic              ref_above_feedback_input,
  input  wire logic              high_side_pulse,
  input  wire logic [4:0]        ss_strap_code,
  input  wire logic [3:0]        mode_strap_code,
  output logic                   high_side_drive_en,
  output logic                   low_side_drive_en,
  output logic [9:0]             ref_level,
  output logic                   power_good_output,
  output logic                   loop_set_small_inductor,
  output logic                   hiccup_response,
  output logic [1:0]             freq_sel,
  output logic                   pulse_skipping_mode,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  import css_pkg::*;

  localparam int        DG_CYC   = (`CSS_DEGLITCH_NS * `CSS_CLK_MHZ) / 1000;
  localparam logic [9:0] REF_FULL = 10'(`CSS_REF_FULL_MV);

  css_state_type    state_q;     // Sequencer state.
  css_state_type    state_d;     // Next sequencer state.
  logic [CNT_W-1:0] cnt_q;       // Shared interval counter, cleared on each state change.
  logic [15:0]      step_q;      // Cycles within one reference step.
  logic [13:0]      sync1_q;     // First synchroniser stage of the pins.
  logic [13:0]      sync2_q;     // Synchronised pins.
  logic             turn_on_f;   // Filtered turn-on level.
  logic             switching_q; // Pulses allowed during this start.
  logic             hs_seen_q;   // A high-side pulse has occurred in this start.
  logic             fc_req_q;    // Software forced-continuous request.
  css_strap_type    strap_q;     // Latched strap results.
  css_strap_if      strap_bus ();

  // Write- and read-side bus state, declared here because the mode logic reads the write side.
  logic              aw_full_q;  // Write address held.
  logic              w_full_q;   // Write data held.
  logic [ADDR_W-1:0] wr_addr_q;  // Held write address.
  logic [31:0]       wr_data_q;  // Held write data.
  logic [3:0]        wr_strb_q;  // Held byte strobes.
  logic              wr_fire;    // Address and data both present and response free.
  logic              rd_take;    // Read address accepted this cycle.
  logic              rvalid_d;   // Next read valid.
  assign wr_fire  = aw_full_q && w_full_q && !s_axi_bvalid;
  assign rd_take  = s_axi_arvalid && s_axi_arready;
  assign rvalid_d = (s_axi_rvalid && !s_axi_rready) || rd_take;

  // Synchronised pin views.
  logic supply_ok_s;
  logic vout_reg_s;
  logic ref_above_s;
  logic hs_pulse_s;
  assign supply_ok_s = sync2_q[0] & sync2_q[1];
  assign vout_reg_s  = sync2_q[2];
  assign ref_above_s = sync2_q[3];
  assign hs_pulse_s  = sync2_q[4];
  assign strap_bus.ss_code   = sync2_q[9:5];
  assign strap_bus.mode_code = sync2_q[13:10];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and helper modules.

  // Every asynchronous pin passes two flip-flops before any logic sees it.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_q <= 14'h0000;
      sync2_q <= 14'h0000;
    end
    else
    begin
      sync1_q <= {mode_strap_code, ss_strap_code, high_side_pulse,
                  ref_above_feedback_input, vout_in_regulation,
                  analog_supply_input_ok, bias_supply_ok};
      sync2_q <= sync1_q;
    end
  end

  css_deglitch #(
    .CYCLES (DG_CYC)
  ) u_deglitch (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (turn_on_pin),
    .level   (turn_on_f)
  );

  css_strap_decode u_decode (
    .strap (strap_bus.decoder)
  );

  // Ramp step length for the latched soft-start selection.
  function automatic logic [15:0] step_limit(input logic [1:0] sel);
    return 16'(STEP_CYC << sel) - 16'h0001;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state.

  // Supply loss overrides everything; turn-on loss aborts any active state.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_OFF:   if (supply_ok_s) state_d = ST_INIT;
      ST_INIT:  if (cnt_q == CNT_W'(INIT_CYC - 1)) state_d = ST_IDLE;
      ST_IDLE:  if (turn_on_f) state_d = ST_DELAY;
      ST_DELAY: if (cnt_q == CNT_W'(POD_CYC - 1)) state_d = ST_SOFT;
      ST_SOFT:  if (ref_level == REF_FULL) state_d = ST_WREG;
      ST_WREG:  if (vout_reg_s) state_d = ST_PGDLY;
      ST_PGDLY: if (cnt_q == CNT_W'(PG_CYC - 1)) state_d = ST_RUN;
      ST_RUN:   state_d = ST_RUN;
      default:  state_d = ST_OFF;
    endcase
    if (state_q != ST_OFF && state_q != ST_INIT && state_q != ST_IDLE && !turn_on_f)
    begin
      state_d = ST_IDLE;
    end
    if (!supply_ok_s)
    begin
      state_d = ST_OFF;
    end
  end

  // State register and shared interval counter.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ST_OFF;
      cnt_q   <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= (state_d != state_q) ? '0 : cnt_q + CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference ramp.

  // The reference is held at zero in off, idle and delay so a restart begins from zero.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ref_level <= 10'h000;
      step_q    <= 16'h0000;
    end
    else if (state_d == ST_IDLE || state_d == ST_OFF || state_d == ST_DELAY)
    begin
      ref_level <= 10'h000;
      step_q    <= 16'h0000;
    end
    else if (state_q == ST_SOFT && ref_level != REF_FULL)
    begin
      if (step_q == step_limit(strap_q.ss_sel))
      begin
        step_q    <= 16'h0000;
        ref_level <= ref_level + 10'h001;
      end
      else
      begin
        step_q <= step_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drivers and power good.

  // Pre-biased starts wait for the reference to pass feedback, then for a high-side pulse.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      switching_q        <= 1'b0;
      hs_seen_q          <= 1'b0;
      high_side_drive_en <= 1'b0;
      low_side_drive_en  <= 1'b0;
      power_good_output  <= 1'b0;
    end
    else if (state_d == ST_IDLE || state_d == ST_OFF || state_d == ST_INIT
             || state_d == ST_DELAY)
    begin
      switching_q        <= 1'b0;
      hs_seen_q          <= 1'b0;
      high_side_drive_en <= 1'b0;
      low_side_drive_en  <= 1'b0;
      power_good_output  <= 1'b0;
    end
    else
    begin
      if (ref_above_s)
      begin
        switching_q <= 1'b1;
      end
      if (switching_q && hs_pulse_s)
      begin
        hs_seen_q <= 1'b1;
      end
      high_side_drive_en <= switching_q;
      low_side_drive_en  <= switching_q && hs_seen_q;
      power_good_output  <= (state_d == ST_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap latch and operating mode.

  // Straps are captured only on the last init cycle; toggling turn-on never recaptures.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      strap_q <= '0;
    end
    else if (state_q == ST_INIT && state_d == ST_IDLE)
    begin
      strap_q <= strap_bus.decoded;
    end
  end

  assign loop_set_small_inductor = strap_q.loop_small;
  assign hiccup_response         = strap_q.hiccup;
  assign freq_sel                = strap_q.freq_sel;

  // The request bit follows software, but the mode only moves when init ends or a turn-on starts.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fc_req_q            <= 1'(`CSS_CTRL_RESET);
      pulse_skipping_mode <= 1'b0;
    end
    else
    begin
      if (wr_fire && wr_addr_q == `CSS_CTRL_OFS && wr_strb_q[0])
      begin
        fc_req_q <= wr_data_q[`CSS_CTRL_FC_BIT];
      end
      else if (state_q == ST_INIT && state_d == ST_IDLE)
      begin
        fc_req_q <= !strap_bus.decoded.pulse_skip;
      end
      if (state_q == ST_INIT && state_d == ST_IDLE)
      begin
        pulse_skipping_mode <= strap_bus.decoded.pulse_skip;
      end
      else if (state_q == ST_IDLE && state_d == ST_DELAY)
      begin
        pulse_skipping_mode <= !fc_req_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.

  // Address and data are taken independently and held until the write is done.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      wr_addr_q     <= '0;
      wr_data_q     <= 32'h0000_0000;
      wr_strb_q     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CSS_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        wr_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wr_data_q <= s_axi_wdata;
        wr_strb_q <= s_axi_wstrb;
      end
      aw_full_q     <= (aw_full_q || (s_axi_awvalid && s_axi_awready)) && !wr_fire;
      w_full_q      <= (w_full_q || (s_axi_wvalid && s_axi_wready)) && !wr_fire;
      s_axi_awready <= !((aw_full_q || (s_axi_awvalid && s_axi_awready)) && !wr_fire);
      s_axi_wready  <= !((w_full_q || (s_axi_wvalid && s_axi_wready)) && !wr_fire);
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_addr_q == `CSS_CTRL_OFS) ? `CSS_RESP_OKAY : `CSS_RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Reads answer one cycle after the address; read-only registers ignore writes.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CSS_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !rvalid_d;
      s_axi_rvalid  <= rvalid_d;
      if (rd_take)
      begin
        s_axi_rresp <= `CSS_RESP_OKAY;
        case (s_axi_araddr)
          `CSS_CTRL_OFS:   s_axi_rdata <= {31'h0000_0000, fc_req_q};
          `CSS_STATUS_OFS: s_axi_rdata <= {20'h0_0000, pulse_skipping_mode, low_side_drive_en,
                                           high_side_drive_en, power_good_output, state_q};
          `CSS_STRAP_OFS:  s_axi_rdata <= {25'h000_0000, strap_q};
          `CSS_REF_OFS:    s_axi_rdata <= {22'h00_0000, ref_level};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CSS_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  AST_INIT_LEN: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_IDLE && $past(state_q) == ST_INIT)
      |-> $past(cnt_q) == CNT_W'(INIT_CYC - 1))
    else $error("initialization left early");
  AST_STRAP_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(state_q) != ST_INIT && state_q != ST_INIT) |-> $stable(strap_q))
    else $error("strap results changed outside initialization");
  AST_POD_TO_SOFT: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_SOFT && $past(state_q) == ST_DELAY) |-> ref_level == 10'h000)
    else $error("soft-start did not begin from zero");
  AST_REF_LIMIT: assert property (@(posedge aclk) disable iff (!aresetn)
    ref_level <= REF_FULL && (ref_level == 10'h000 || state_q != ST_DELAY))
    else $error("reference out of range");
  AST_PREBIAS_LS: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(low_side_drive_en) |-> $past(hs_seen_q) && high_side_drive_en)
    else $error("low side enabled before a high-side pulse");
  AST_PULSE_START: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(switching_q) |-> $past(ref_above_s))
    else $error("switching began before reference crossed feedback");
  AST_PG_DELAY: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(power_good_output) |-> $past(state_q) == ST_PGDLY
      && $past(cnt_q) == CNT_W'(PG_CYC - 1))
    else $error("power good raised without the full delay");
  AST_SHUTDOWN: assert property (@(posedge aclk) disable iff (!aresetn)
    (!turn_on_f && state_q != ST_OFF && state_q != ST_INIT) |=>
      !high_side_drive_en && !low_side_drive_en && ref_level == 10'h000)
    else $error("drivers or reference not cleared on turn-off");
  AST_MODE_DEFER: assert property (@(posedge aclk) disable iff (!aresetn)
    !$stable(pulse_skipping_mode)
      |-> $past(state_q) == ST_INIT || $past(state_q) == ST_IDLE)
    else $error("operating mode changed while enabled");
endmodule

// >>> css_ctrl_model.sv
// Behavioural system controller and output stage facing the sequencer.
`timescale 1ns/1ps
module css_ctrl_model (
  input  wire logic       aclk,
  input  wire logic       en_req,
  input  wire logic [9:0] prebias_mv,
  input  wire logic [9:0] ref_level,
  input  wire logic       high_side_drive_en,
  output logic            turn_on_pin,
  output logic            vout_in_regulation,
  output logic            ref_above_feedback_input,
  output logic            high_side_pulse
);
  // The controller passes its request straight to the pin.
  assign turn_on_pin = en_req;
  // Feedback sits at the pre-biased level until the ramp passes it.
  assign ref_above_feedback_input = ref_level > prebias_mv;
  // Regulation is only reached at the full reference.
  assign vout_in_regulation = ref_level == 10'h320;
  // A pulse follows every cycle with the high side enabled.
  initial high_side_pulse = 1'b0;
  always @(posedge aclk)
    high_side_pulse <= high_side_drive_en;
endmodule

// >>> css_sequencer_tb.sv
// Self-checking bench for the start-up sequencer.
`timescale 1ns/1ps
module css_sequencer_tb;
  import css_pkg::*;
  localparam int INIT = 50, POD = 50, GOOD = 50, STEP = 2;
  logic        aclk = 0, aresetn = 0, bias = 0, ana = 0, en = 0, seen = 0;
  logic [9:0]  pre = 0, refl;
  logic [4:0]  ssc = 0;
  logic [3:0]  mdc = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, hs, ls, pgood, lp, hc, ps;
  logic        ton, vreg, above, hsp;
  logic [1:0]  fs, bresp, rresp, r;
  logic [6:0]  e;
  int          n, n_mismatch = 0, n_compared = 0, cyc = 0;
  always #4 aclk = ~aclk;
  ////////////////////////////////////////
  css_sequencer #(.INIT_CYC(INIT), .POD_CYC(POD), .PG_CYC(GOOD), .STEP_CYC(STEP)) uut (
    .aclk(aclk), .aresetn(aresetn), .bias_supply_ok(bias), .analog_supply_input_ok(ana),
    .turn_on_pin(ton), .vout_in_regulation(vreg), .ref_above_feedback_input(above),
    .high_side_pulse(hsp), .ss_strap_code(ssc), .mode_strap_code(mdc),
    .high_side_drive_en(hs), .low_side_drive_en(ls), .ref_level(refl),
    .power_good_output(pgood), .loop_set_small_inductor(lp), .hiccup_response(hc),
    .freq_sel(fs), .pulse_skipping_mode(ps), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  css_ctrl_model partner (.aclk(aclk), .en_req(en), .prebias_mv(pre), .ref_level(refl),
    .high_side_drive_en(hs), .turn_on_pin(ton), .vout_in_regulation(vreg),
    .ref_above_feedback_input(above), .high_side_pulse(hsp));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Both bus tasks start just after an edge and leave the response code in r.
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic got;
    got = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!got)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 0;
      if (wready)
        wvalid <= 0;
      got = bvalid;
      r = bresp;
    end
    bready <= 0;
    @(posedge aclk);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    logic got;
    got = 0;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!got)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 0;
      got = rvalid;
      d = rdata;
      r = rresp;
    end
    rready <= 0;
    @(posedge aclk);
  endtask
  // Expected latched strap word: soft-start, loop, response, frequency, mode.
  function automatic logic [6:0] dec(input logic [4:0] s, input logic [3:0] m);
    dec[6:3] = s[4] ? 4'b1000 : {s[1:0], s[2], s[3]};
    dec[2:0] = m[3] ? 3'b010 : {m[1:0], m[2]};
  endfunction
  // Counts edges until ramp start, full ramp, power good or high side off.
  task automatic till(input int w, output int k);
    logic c;
    k = 0;
    c = 0;
    while (!c)
    begin
      @(posedge aclk);
      k++;
      case (w)
        0: c = refl != 0;
        1: c = refl == 10'h320;
        2: c = pgood;
        default: c = !hs;
      endcase
    end
  endtask
  task automatic stop;
    en <= 0;
    till(3, n);
    chk(n >= 25 && n <= 34, 1);
    chk({ls, pgood, refl}, 0);
  endtask
  task automatic idle_chk;
    en <= 0;
    repeat (40) @(posedge aclk);
    axr(8'h04, rd);
    chk({rd[7:0], refl}, {8'h04, 10'h0});
  endtask
  ////////////////////////////////////////
  // Settled-value watch on the drivers during every start.
  always @(negedge aclk)
  begin
    if (hsp)
      seen = 1;
    if (!hs && !ls)
      seen = 0;
    if (ls === 1'b1)
      chk(seen, 1);
    if (hs === 1'b1)
      chk(refl > pre, 1);
  end
  // A hung handshake or sequence ends the run here.
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  initial
  begin
    void'($urandom(17));
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    axr(8'h00, rd);
    chk(rd, 32'h0000_0001);
    axr(8'h10, rd);
    chk(r, 2'h2);
    chk(rd, 32'h0000_0000);
    axw(8'h04, 32'h0000_0001);
    chk(r, 2'h2);
    for (int i = 0; i < 5; i++)
    begin
      // Alternate the supply that is cycled; each must force fresh detection.
      if (i[0])
        bias <= 0;
      else
        ana <= 0;
      ssc <= (i == 4) ? 5'h10 : {1'b0, 2'($urandom), 2'(i)};
      mdc <= (i == 4) ? 4'h8 : {1'b0, 3'($urandom)};
      repeat (4) @(posedge aclk);
      bias <= 1;
      ana <= 1;
      repeat (30) @(posedge aclk);
      axr(8'h04, rd);
      chk(rd[7:0], 8'h02);
      repeat (40) @(posedge aclk);
      e = dec(ssc, mdc);
      axr(8'h08, rd);
      chk(rd[6:0], e);
      chk({lp, hc, fs, ps}, e[4:0]);
      axr(8'h00, rd);
      chk(rd[0], !e[0]);
      ssc <= ~ssc;
      mdc <= ~mdc;
      pre <= 10'($urandom_range(400));
      en <= 1;
      till(0, n);
      chk(n >= POD + 25 && n <= POD + 40 + (STEP << e[6:5]), 1);
      till(1, n);
      chk(n >= 799 * (STEP << e[6:5]) - 4 && n <= 799 * (STEP << e[6:5]) + 4, 1);
      till(2, n);
      chk(n >= GOOD && n <= GOOD + 8, 1);
      if (i == 1)
      begin
        axw(8'h00, {31'h0, e[0]});
        repeat (5) @(posedge aclk);
        chk({r, ps}, {2'h0, e[0]});
        stop();
        en <= 1;
        till(1, n);
        chk(ps, !e[0]);
      end
      stop();
      chk({lp, hc, fs}, e[4:1]);
    end
    en <= 1;
    repeat (60) @(posedge aclk);
    idle_chk();
    en <= 1;
    till(0, n);
    chk(n >= POD + 25 && n <= POD + 40 + (STEP << e[6:5]), 1);
    idle_chk();
    en <= 1;
    repeat (10) @(posedge aclk);
    en <= 0;
    axr(8'h04, rd);
    chk(rd[7:0], 8'h04);
    idle_chk();
    en <= 1;
    till(0, n);
    bias <= 0;
    repeat (6) @(posedge aclk);
    axr(8'h04, rd);
    chk({rd[7:0], hs, refl}, {8'h01, 11'h0});
    conclude();
  end
endmodule
